// File: sfw_map.svh
// register offsets, field positions, reset values for the synth frequency word bank
`ifndef SFW_MAP_SVH
`define SFW_MAP_SVH
// register indices (printed offsets are not multiples of four)
`define SFW_IDX_CTRL_ONE    16'hDF07
`define SFW_IDX_OFFSET      16'hDF08
`define SFW_IDX_WORD_HIGH   16'hDF09
`define SFW_IDX_WORD_MID    16'hDF0A
`define SFW_IDX_WORD_LOW    16'hDF0B
`define SFW_IDX_SLOT        16'hDF06
`define SFW_IDX_IF          16'hDF07
`define SFW_IDX_SPACING     16'hDF40
`define SFW_IDX_STATUS      16'hDF41
`define SFW_IDX_COMMAND     16'hDF42
// reset values
`define SFW_RST_OFFSET      8'h00
`define SFW_RST_WORD_HIGH   6'h1E
`define SFW_RST_WORD_MID    8'hC4
`define SFW_RST_WORD_LOW    8'hEC
`define SFW_RST_SLOT        8'h00
`define SFW_RST_IF          5'h0F
`define SFW_RST_SPACING     16'h0000
// field positions
`define SFW_HIGH_RW_MSB     5
`define SFW_IF_MSB          4
`define SFW_CMD_APPLY_BIT   0
`define SFW_STAT_RX_BIT     0
// offset step is four carrier steps (2^16 / 2^14)
`define SFW_OFFSET_SHIFT    2
`endif

// File: sfw_pkg.sv
// types shared by the synth frequency word bank
package sfw_pkg;
	typedef logic [23:0] sfw_word_t;   // 24-bit synthesizer word
	typedef logic [7:0]  sfw_byte_t;   // one register byte
	typedef enum logic [1:0] {
		SFW_RESP_OKAY   = 2'h0,
		SFW_RESP_SLVERR = 2'h2
	} sfw_resp_t;
endpackage : sfw_pkg

// File: sfw_word_calc.sv
// combines base word, channel, offset and intermediate setting into the synth word
`timescale 1ns/1ps
`include "sfw_map.svh"
module sfw_word_calc #(
	parameter int SPACING_W = 16
) (
	input  wire logic [23:0]          base_word,
	input  wire logic [7:0]           slot_number,
	input  wire logic [SPACING_W-1:0] slot_spacing,
	input  wire logic [7:0]           offset_correction,
	input  wire logic [4:0]           intermediate_offset_setting,
	input  wire logic                 rx_active,
	output      logic [23:0]          synth_word
);
	// spacing must fit in the 24-bit word together with an 8-bit multiplier
	if (SPACING_W < 1 || SPACING_W > 16) begin : g_bad_width
		$error("sfw_word_calc: SPACING_W out of range");
	end
	wire logic [23:0] slot_product; // channel times spacing
	wire logic [23:0] offset_ext;   // sign-extended, scaled offset
	wire logic [23:0] if_term;      // if removed only in receive
	// widen both factors first, a self-sized product would lose its top byte
	assign slot_product = 24'(slot_number) * 24'(slot_spacing);            // [RQ10]
	// offset lsb is four word lsbs, so scale by shift after sign extension
	assign offset_ext   = 24'({{16{offset_correction[7]}}, offset_correction}
		<< `SFW_OFFSET_SHIFT);                                             // [RQ12] [RQ2]
	assign if_term      = rx_active ? {19'h0, intermediate_offset_setting} : 24'h0; // [RQ11]
	// modular 24-bit sum; wraps rather than saturating at the word ends
	assign synth_word   = 24'(base_word + slot_product + offset_ext - if_term); // [RQ1] [RQ5]
endmodule : sfw_word_calc

// File: sfw_regs.sv
// synth frequency word register bank with an AXI4-Lite slave
// Behaviour
// RQ1: signed offset added to base word
// RQ2: offset step is crystal over 2^14
// RQ3: apply strobe or afc adds estimate to offset
// RQ4: word bits 23:22 read-only, reset zero
// RQ5: word lsb is crystal over 2^16
// RQ6: high byte holds word bits 21:16
// RQ7: middle byte holds word bits 15:8
// RQ8: low byte holds word bits 7:0
// RQ9: word resets to 1E C4 EC
// RQ10: channel times spacing added to base
// RQ11: receive subtracts intermediate setting from base
// RQ12: sign-extend offset, shift left two, add
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sfw_map.svh"
module sfw_regs #(
	parameter int SPACING_W = 16
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write address
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output      logic                 s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output      logic                 s_axi_wready,
	// axi4-lite write response
	output      logic [1:0]           s_axi_bresp,
	output      logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output      logic                 s_axi_arready,
	// axi4-lite read data
	output      logic [31:0]          s_axi_rdata,
	output      logic [1:0]           s_axi_rresp,
	output      logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// modem side, same clock domain
	input  wire logic [7:0]           afc_estimate,
	input  wire logic                 afc_act,
	input  wire logic                 rx_active,
	output      logic [23:0]          synth_word
);
	// refuse widths the read mux and the 24-bit product cannot serve
	if (SPACING_W < 1 || SPACING_W > 16) begin : g_bad_width
		$error("sfw_regs: SPACING_W out of range");
	end

	// register index from byte address; upper bits must be zero
	function automatic logic [15:0] idx_of(input logic [31:0] addr);
		idx_of = (addr[31:18] == 14'h0 && addr[1:0] == 2'h0) ? addr[17:2] : 16'hFFFF;
	endfunction : idx_of

	// storage
	logic [7:0]           offset_r;      // offset correction
	logic [5:0]           word_high_r;   // word bits 21:16
	logic [7:0]           word_mid_r;    // word bits 15:8
	logic [7:0]           word_low_r;    // word bits 7:0
	logic [7:0]           slot_r;        // channel index
	logic [4:0]           if_r;          // intermediate setting
	logic [SPACING_W-1:0] spacing_r;     // channel spacing in word steps
	logic [7:0]           offset_nxt;
	// bus state
	logic                 aw_held_r;     // write address captured
	logic                 w_held_r;      // write data captured
	logic [31:0]          awaddr_r;
	logic [31:0]          wdata_r;
	logic [3:0]           wstrb_r;
	logic                 awready_r;
	logic                 wready_r;
	logic                 bvalid_r;
	logic [1:0]           bresp_r;
	logic                 arready_r;
	logic                 rvalid_r;
	logic [31:0]          rdata_r;
	logic [1:0]           rresp_r;
	logic [23:0]          synth_word_r;
	logic                 rx_q1_r;       // rx flag is same domain, no sync needed

	// write decode
	wire logic        do_write;  // both halves held, response slot free
	wire logic [15:0] widx;
	wire logic        wlane0;    // low byte lane enabled
	wire logic        wmapped;
	wire logic        wr_offset;
	wire logic        wr_high;
	wire logic        wr_mid;
	wire logic        wr_low;
	wire logic        wr_slot;
	wire logic        wr_if;
	wire logic        wr_spacing;
	wire logic        wr_cmd;
	wire logic        apply_hit; // software strobe or afc event
	assign do_write   = aw_held_r && w_held_r && !bvalid_r;
	assign widx       = idx_of(awaddr_r);
	assign wlane0     = wstrb_r[0];
	assign wr_offset  = do_write && wlane0 && widx == `SFW_IDX_OFFSET;
	assign wr_high    = do_write && wlane0 && widx == `SFW_IDX_WORD_HIGH;
	assign wr_mid     = do_write && wlane0 && widx == `SFW_IDX_WORD_MID;
	assign wr_low     = do_write && wlane0 && widx == `SFW_IDX_WORD_LOW;
	assign wr_slot    = do_write && wlane0 && widx == `SFW_IDX_SLOT;
	assign wr_if      = do_write && wlane0 && widx == `SFW_IDX_IF;
	assign wr_spacing = do_write && widx == `SFW_IDX_SPACING;
	assign wr_cmd     = do_write && wlane0 && widx == `SFW_IDX_COMMAND;
	assign wmapped    = widx == `SFW_IDX_OFFSET || widx == `SFW_IDX_WORD_HIGH ||
		widx == `SFW_IDX_WORD_MID || widx == `SFW_IDX_WORD_LOW ||
		widx == `SFW_IDX_SLOT || widx == `SFW_IDX_IF ||
		widx == `SFW_IDX_SPACING || widx == `SFW_IDX_COMMAND ||
		widx == `SFW_IDX_STATUS;
	assign apply_hit  = (wr_cmd && wdata_r[`SFW_CMD_APPLY_BIT]) || afc_act;

	// offset update: accumulation wins over a plain write in the same cycle,
	// so an afc event is never lost behind software
	always_comb begin
		offset_nxt = offset_r;
		if (wr_offset) begin
			offset_nxt = wdata_r[7:0];
		end
		if (apply_hit) begin
			offset_nxt = 8'(offset_r + afc_estimate); // [RQ3]
		end
	end

	// read decode
	wire logic [15:0] ridx;
	wire logic [31:0] rword;     // selected read value
	wire logic        rmapped;
	assign ridx = idx_of(s_axi_araddr);
	// the two top word bits read as zero and cannot be written
	assign rword =
		(ridx == `SFW_IDX_OFFSET)    ? {24'h0, offset_r} :
		(ridx == `SFW_IDX_WORD_HIGH) ? {24'h0, 2'b00, word_high_r} :   // [RQ4] [RQ6]
		(ridx == `SFW_IDX_WORD_MID)  ? {24'h0, word_mid_r} :           // [RQ7]
		(ridx == `SFW_IDX_WORD_LOW)  ? {24'h0, word_low_r} :           // [RQ8]
		(ridx == `SFW_IDX_SLOT)      ? {24'h0, slot_r} :
		(ridx == `SFW_IDX_IF)        ? {27'h0, if_r} :
		(ridx == `SFW_IDX_SPACING)   ? {{(32-SPACING_W){1'b0}}, spacing_r} :
		(ridx == `SFW_IDX_STATUS)    ? {31'h0, rx_q1_r} :
		32'h0000_0000;
	assign rmapped = ridx == `SFW_IDX_OFFSET || ridx == `SFW_IDX_WORD_HIGH ||
		ridx == `SFW_IDX_WORD_MID || ridx == `SFW_IDX_WORD_LOW ||
		ridx == `SFW_IDX_SLOT || ridx == `SFW_IDX_IF ||
		ridx == `SFW_IDX_SPACING || ridx == `SFW_IDX_STATUS ||
		ridx == `SFW_IDX_COMMAND;

	// write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= 32'h0000_0000;
			awready_r <= 1'b0;
		end else if (s_axi_awvalid && awready_r) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
			awready_r <= 1'b0;
		end else begin
			if (do_write) begin
				aw_held_r <= 1'b0;
			end
			awready_r <= !aw_held_r && !do_write && !awready_r;
		end
	end

	// write data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			wready_r <= 1'b0;
		end else if (s_axi_wvalid && wready_r) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
			wready_r <= 1'b0;
		end else begin
			if (do_write) begin
				w_held_r <= 1'b0;
			end
			wready_r <= !w_held_r && !do_write && !wready_r;
		end
	end

	// write response, slverr for unmapped index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= sfw_pkg::SFW_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wmapped ? sfw_pkg::SFW_RESP_OKAY : sfw_pkg::SFW_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// register storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_r    <= `SFW_RST_OFFSET;
			word_high_r <= `SFW_RST_WORD_HIGH;                            // [RQ9]
			word_mid_r  <= `SFW_RST_WORD_MID;                             // [RQ9]
			word_low_r  <= `SFW_RST_WORD_LOW;                             // [RQ9]
			slot_r      <= `SFW_RST_SLOT;
			if_r        <= `SFW_RST_IF;
			spacing_r   <= SPACING_W'(`SFW_RST_SPACING);
		end else begin
			offset_r <= offset_nxt;
			if (wr_high) begin
				word_high_r <= wdata_r[`SFW_HIGH_RW_MSB:0];                 // [RQ6]
			end
			if (wr_mid) begin
				word_mid_r <= wdata_r[7:0];                                 // [RQ7]
			end
			if (wr_low) begin
				word_low_r <= wdata_r[7:0];                                 // [RQ8]
			end
			if (wr_slot) begin
				slot_r <= wdata_r[7:0];
			end
			if (wr_if) begin
				if_r <= wdata_r[`SFW_IF_MSB:0];
			end
			if (wr_spacing) begin
				spacing_r <= wdata_r[SPACING_W-1:0];
			end
		end
	end

	// read channel: one-cycle arready pulse, data one edge later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= sfw_pkg::SFW_RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rword;
			rresp_r   <= rmapped ? sfw_pkg::SFW_RESP_OKAY : sfw_pkg::SFW_RESP_SLVERR;
		end else begin
			if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
			arready_r <= !rvalid_r && !arready_r && s_axi_arvalid;
		end
	end

	// synthesizer word, registered so the output comes from a flop
	wire logic [23:0] word_comb;
	wire logic [23:0] base_word;
	assign base_word = {2'b00, word_high_r, word_mid_r, word_low_r};     // [RQ4] [RQ5]
	sfw_word_calc #(
		.SPACING_W (SPACING_W)
	) u_calc (
		.base_word                   (base_word),
		.slot_number                 (slot_r),
		.slot_spacing                (spacing_r),
		.offset_correction           (offset_r),
		.intermediate_offset_setting (if_r),
		.rx_active                   (rx_active),
		.synth_word                  (word_comb)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			synth_word_r <= 24'h00_0000;
			rx_q1_r      <= 1'b0;
		end else begin
			synth_word_r <= word_comb;                                     // [RQ1]
			rx_q1_r      <= rx_active;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign synth_word    = synth_word_r;
endmodule : sfw_regs

// File: sfw_regs_asserts.sv
// bus and word checks for the synth frequency word bank
`timescale 1ns/1ps
module sfw_regs_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        afc_act,
	input wire logic        rx_active,
	input wire logic [23:0] synth_word
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// response held until taken
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	// fixed answer times from the hand-over walk
	w_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	// refused reads return zero
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("refused read carries data");
	// outputs quiet just after reset
	rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
		else $error("response valid after reset");
	// word only moves on a cause; rx edges and writes need settling time
	word_stable_a: assert property ((aresetn && !afc_act && !s_axi_bvalid && !s_axi_wvalid
		&& $stable(rx_active))[*3] |-> $stable(synth_word)) else $error("word moved");
	rst_word_a: assert property ($rose(aresetn) |=> ##1 synth_word == 24'h1EC4EC)
		else $error("word reset value wrong");
	c_write_c: cover property (s_axi_bvalid && s_axi_bready);
	c_read_c: cover property (s_axi_rvalid && s_axi_rready);
	c_afc_c: cover property (afc_act);
endmodule : sfw_regs_asserts

// File: sfw_regs_bench.sv
// self-checking bench for the synth frequency word bank
`timescale 1ns/1ps
`include "sfw_map.svh"
module sfw_regs_bench;
	logic        aclk = '0, aresetn = '0, afc_act = '0, rx_active = '0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic        s_axi_arvalid = '0, s_axi_rready = '0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]  afc_estimate = '0, hi = 8'h1E, mid = 8'hC4, lo = 8'hEC, off = '0, slot = '0;
	logic [4:0]  ifv = 5'h0F;      // intermediate setting shadow
	logic [15:0] spc = '0;         // spacing shadow
	logic [23:0] synth_word;
	logic [31:0] v, u, d;          // random draws and read data
	int          i, fail_count = 0, cmp_count = 0;
	sfw_regs i_dut (.*);
	// 100 MHz clock
	always #5 aclk = ~aclk;
	// expected word from the shadow registers
	function automatic logic [23:0] exp_word();
		exp_word = {2'h0, hi[5:0], mid, lo} + slot * spc + {{14{off[7]}}, off, 2'h0}
			- (rx_active ? {19'h0, ifv} : 24'h0);
	endfunction : exp_word
	// verdict, also reached on timeout
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t data %h exp %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t word %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	// write: address and data offered together, bready held until bvalid
	task automatic axw(input logic [31:0] a, input logic [31:0] wd, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n == 40) begin
			fail_count++;
			conclude();
		end
	endtask : axw
	// read: rready held until rvalid
	task automatic axr(input logic [31:0] a, output logic [31:0] rd, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (n == 40) begin
			fail_count++;
			conclude();
		end
	endtask : axr
	task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
		axw({14'h0, idx, 2'h0}, wd, rs);
		chk_data({30'h0, rs}, 32'h0);
	endtask : wr
	task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
		axr({14'h0, idx, 2'h0}, d, rs);
		chk_data(d, e);
		chk_data({30'h0, rs}, 32'h0);
	endtask : rchk
	// main sequence
	initial begin
		void'($urandom(52));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		chk_word(synth_word, 24'h1EC4EC);
		rchk(`SFW_IDX_WORD_HIGH, 32'h1E);
		rchk(`SFW_IDX_WORD_MID, 32'hC4);
		rchk(`SFW_IDX_WORD_LOW, 32'hEC);
		rchk(`SFW_IDX_OFFSET, 32'h0);
		// random words; first pass hits top bits, most negative offset, max product
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 32'hFF80FF80 : $urandom;
			u = (i == 0) ? 32'hFFFFFF79 : $urandom;
			rx_active <= u[0];
			wr(`SFW_IDX_WORD_HIGH, {24'h0, v[31:24]});
			wr(`SFW_IDX_WORD_MID, {24'h0, v[23:16]});
			wr(`SFW_IDX_WORD_LOW, {24'h0, v[15:8]});
			wr(`SFW_IDX_OFFSET, {24'h0, v[7:0]});
			wr(`SFW_IDX_SLOT, {24'h0, u[15:8]});
			wr(`SFW_IDX_SPACING, {16'h0, u[31:16]});
			wr(`SFW_IDX_IF, {27'h0, u[7:3]});
			{hi, mid, lo, off} = v;
			{spc, slot} = u[31:8];
			ifv = u[7:3];
			repeat (3) @(posedge aclk);
			chk_word(synth_word, exp_word());
			rchk(`SFW_IDX_WORD_HIGH, {26'h0, hi[5:0]});
			rchk(`SFW_IDX_WORD_MID, {24'h0, mid});
			rchk(`SFW_IDX_WORD_LOW, {24'h0, lo});
			rchk(`SFW_IDX_SLOT, {24'h0, slot});
			rchk(`SFW_IDX_SPACING, {16'h0, spc});
			rchk(`SFW_IDX_IF, {27'h0, ifv});
			rchk(`SFW_IDX_STATUS, {31'h0, rx_active});
		end
		// estimate folded in by afc pulse and by command strobe, in turn
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'h80 : $urandom;
			@(posedge aclk);
			afc_estimate <= v[7:0];
			if (i[0]) wr(`SFW_IDX_COMMAND, 32'h1);
			else begin
				afc_act <= 1'h1;
				@(posedge aclk);
				afc_act <= 1'h0;
			end
			off = off + v[7:0];
			repeat (4) @(posedge aclk);
			chk_word(synth_word, exp_word());
			rchk(`SFW_IDX_OFFSET, {24'h0, off});
		end
		// misaligned and unmapped places are refused, nothing stored
		axw({14'h0, `SFW_IDX_WORD_LOW, 2'h1}, 32'h55, rs);
		chk_data({30'h0, rs}, 32'h2);
		axr({14'h0, 16'hDF43, 2'h0}, d, rs);
		chk_data(d, 32'h0);
		chk_data({30'h0, rs}, 32'h2);
		rchk(`SFW_IDX_WORD_LOW, {24'h0, lo});
		// second reset mid-run
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rx_active <= 1'h0;
		repeat (3) @(posedge aclk);
		chk_word(synth_word, 24'h1EC4EC);
		conclude();
	end
endmodule : sfw_regs_bench
bind sfw_regs sfw_regs_asserts i_chk (.*);
